// ===== logic/dspcg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dspcg_consts.svh"
//////////////////////////////////////////////////////////////////////
module dspcg_top
  import dspcg_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire dspcg_bus_t bus_req,
  output logic [31:0] rdata_r,
  input wire dspcg_mode_t pwr_mode,
  input wire dspcg_acc_t acc,
  output logic acc_ok_r,
  output logic acc_fault_r,
  output logic [`DSPCG_NUNITS-1:0] unit_clk_en_r
);

  //////////////////////////////////////////////////////////////////////
  // register file state
  logic [31:0] run_clock_gate_1_r;
  logic [31:0] run_clock_gate_1_nxt;
  logic [31:0] sleep_clock_gate_1_r;
  logic [31:0] sleep_clock_gate_1_nxt;
  logic [31:0] deep_sleep_clock_gate_1_r;
  logic [31:0] deep_sleep_clock_gate_1_nxt;
  logic [31:0] run_mode_clock_config_r;
  logic [31:0] run_mode_clock_config_nxt;
  logic [31:0] rdata_nxt;
  logic auto_gating_select;

  assign auto_gating_select = run_mode_clock_config_r[`DSPCG_AUTO_SEL_BIT];

  // writes keep only the implemented bits
  always_comb begin
    run_clock_gate_1_nxt = run_clock_gate_1_r;
    sleep_clock_gate_1_nxt = sleep_clock_gate_1_r;
    deep_sleep_clock_gate_1_nxt = deep_sleep_clock_gate_1_r;
    run_mode_clock_config_nxt = run_mode_clock_config_r;
    rdata_nxt = 32'h0000_0000;
    if (bus_req.wr) begin
      if (bus_req.addr == `DSPCG_OFS_DSL) begin
        deep_sleep_clock_gate_1_nxt = bus_req.wdata & `DSPCG_GATE_MASK;
      end else if (bus_req.addr == `DSPCG_OFS_SLP) begin
        sleep_clock_gate_1_nxt = bus_req.wdata & `DSPCG_GATE_MASK;
      end else if (bus_req.addr == `DSPCG_OFS_RUN) begin
        run_clock_gate_1_nxt = bus_req.wdata & `DSPCG_GATE_MASK;
      end else if (bus_req.addr == `DSPCG_OFS_MODE_CFG) begin
        run_mode_clock_config_nxt[`DSPCG_AUTO_SEL_BIT] = bus_req.wdata[`DSPCG_AUTO_SEL_BIT];
      end
    end
    if (bus_req.rd) begin
      if (bus_req.addr == `DSPCG_OFS_DSL) begin
        rdata_nxt = deep_sleep_clock_gate_1_r;
      end else if (bus_req.addr == `DSPCG_OFS_SLP) begin
        rdata_nxt = sleep_clock_gate_1_r;
      end else if (bus_req.addr == `DSPCG_OFS_RUN) begin
        rdata_nxt = run_clock_gate_1_r;
      end else if (bus_req.addr == `DSPCG_OFS_MODE_CFG) begin
        rdata_nxt = run_mode_clock_config_r;
      end
    end
  end

  // register update; all words start gated off
  always_ff @(posedge clk) begin
    if (srst) begin
      run_clock_gate_1_r <= `DSPCG_GATE_RST;
      sleep_clock_gate_1_r <= `DSPCG_GATE_RST;
      deep_sleep_clock_gate_1_r <= `DSPCG_GATE_RST;
      run_mode_clock_config_r <= `DSPCG_RCC_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      run_clock_gate_1_r <= run_clock_gate_1_nxt;
      sleep_clock_gate_1_r <= sleep_clock_gate_1_nxt;
      deep_sleep_clock_gate_1_r <= deep_sleep_clock_gate_1_nxt;
      run_mode_clock_config_r <= run_mode_clock_config_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // gate word in force and its unit enables
  logic [31:0] gate_eff;
  logic [`DSPCG_NUNITS-1:0] unit_en;
  logic [`DSPCG_NUNITS-1:0] unit_clk_en_nxt;

  // low-power words only apply with auto gating set
  always_comb begin
    gate_eff = run_clock_gate_1_r;
    if (auto_gating_select) begin
      case (pwr_mode)
        pm_sleep: gate_eff = sleep_clock_gate_1_r;
        pm_deep: gate_eff = deep_sleep_clock_gate_1_r;
        default: gate_eff = run_clock_gate_1_r;
      endcase
    end
  end

  // one enable per unit; index 7 is never a unit
  always_comb begin
    unit_en = '0;
    unit_en[0] = gate_eff[`DSPCG_B_ASYNC_ZERO];
    unit_en[1] = gate_eff[`DSPCG_B_ASYNC_ONE];
    unit_en[2] = gate_eff[`DSPCG_B_SYNC_ZERO];
    unit_en[3] = gate_eff[`DSPCG_B_TMR0];
    unit_en[4] = gate_eff[`DSPCG_B_TMR1];
    unit_en[5] = gate_eff[`DSPCG_B_TMR2];
    unit_en[6] = gate_eff[`DSPCG_B_CMP_ZERO];
    unit_clk_en_nxt = unit_en;
  end

  // enables leave a flop so the clock gate cell sees no glitch
  always_ff @(posedge clk) begin
    if (srst) begin
      unit_clk_en_r <= '0;
    end else begin
      unit_clk_en_r <= unit_clk_en_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // peripheral access check
  logic acc_ok_nxt;
  logic acc_fault_nxt;

  // a request to a stopped unit faults instead of completing
  always_comb begin
    acc_ok_nxt = 1'b0;
    acc_fault_nxt = 1'b0;
    if (acc.req) begin
      if (unit_clk_en_r[acc.unit]) begin
        acc_ok_nxt = 1'b1;
      end else begin
        acc_fault_nxt = 1'b1;
      end
    end
  end

  // answers are one-cycle pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_ok_r <= 1'b0;
      acc_fault_r <= 1'b0;
    end else begin
      acc_ok_r <= acc_ok_nxt;
      acc_fault_r <= acc_fault_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  reset_zero_a: assert property (@(posedge clk)
    $past(srst) |-> unit_clk_en_r == '0 && deep_sleep_clock_gate_1_r == 32'h0000_0000)
    else $error("state not cleared by reset");

  dsl_read_a: assert property (@(posedge clk) disable iff (srst)
    bus_req.rd && bus_req.addr == `DSPCG_OFS_DSL
    |=> rdata_r == $past(deep_sleep_clock_gate_1_r))
    else $error("deep-sleep word read back wrong");

  dsl_write_a: assert property (@(posedge clk) disable iff (srst)
    bus_req.wr && bus_req.addr == `DSPCG_OFS_DSL
    |=> deep_sleep_clock_gate_1_r == ($past(bus_req.wdata) & 32'h0107_0013))
    else $error("deep-sleep write not masked");

  reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
    (deep_sleep_clock_gate_1_r & 32'hFEF8_FFEC) == 32'h0000_0000
    && (rdata_r & 32'hF7FF_FFFF & 32'hFEF8_FFEC) == 32'h0000_0000)
    else $error("reserved bit set");

  fault_gated_a: assert property (@(posedge clk) disable iff (srst)
    acc.req && !unit_clk_en_r[acc.unit] |=> acc_fault_r && !acc_ok_r)
    else $error("gated unit access did not fault");

  ok_clocked_a: assert property (@(posedge clk) disable iff (srst)
    acc.req && unit_clk_en_r[acc.unit] |=> acc_ok_r && !acc_fault_r)
    else $error("clocked unit access faulted");

  deep_select_a: assert property (@(posedge clk) disable iff (srst)
    auto_gating_select && pwr_mode == pm_deep
    |=> unit_clk_en_r[6] == $past(deep_sleep_clock_gate_1_r[24])
    && unit_clk_en_r[3] == $past(deep_sleep_clock_gate_1_r[16]))
    else $error("deep-sleep word not in force");

  run_hold_a: assert property (@(posedge clk) disable iff (srst)
    !auto_gating_select |=> unit_clk_en_r[5:0] == {$past(run_clock_gate_1_r[18:16]),
    $past(run_clock_gate_1_r[4]), $past(run_clock_gate_1_r[1:0])})
    else $error("run word not kept with auto gating clear");

  bit_map_a: assert property (@(posedge clk) disable iff (srst)
    auto_gating_select && pwr_mode == pm_deep ##1 auto_gating_select && pwr_mode == pm_deep
    |=> unit_clk_en_r[5:4] == $past(deep_sleep_clock_gate_1_r[18:17]))
    else $error("timer enables mapped wrong");

  no_unit7_a: assert property (@(posedge clk) disable iff (srst)
    !unit_clk_en_r[7])
    else $error("spare enable set");

  serial_map_a: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> unit_clk_en_r[2] == $past(gate_eff[4]))
    else $error("serial enable wrong");

  // the other two gate words take writes like the deep word
  slp_write_a: assert property (@(posedge clk) disable iff (srst)
    bus_req.wr && bus_req.addr == `DSPCG_OFS_SLP
    |=> sleep_clock_gate_1_r == ($past(bus_req.wdata) & `DSPCG_GATE_MASK))
    else $error("sleep write not masked");

  run_write_a: assert property (@(posedge clk) disable iff (srst)
    bus_req.wr && bus_req.addr == `DSPCG_OFS_RUN
    |=> run_clock_gate_1_r == ($past(bus_req.wdata) & `DSPCG_GATE_MASK))
    else $error("run write not masked");

  // only the auto gating select bit lives in the mode config word
  cfg_write_a: assert property (@(posedge clk) disable iff (srst)
    bus_req.wr && bus_req.addr == `DSPCG_OFS_MODE_CFG
    |=> auto_gating_select == $past(bus_req.wdata[`DSPCG_AUTO_SEL_BIT]))
    else $error("auto gating select not written");

  cfg_only_sel_a: assert property (@(posedge clk) disable iff (srst)
    (run_mode_clock_config_r & ~(32'h0000_0001 << `DSPCG_AUTO_SEL_BIT)) == 32'h0000_0000)
    else $error("mode config holds stray bits");

  // read data stands one cycle and is zero otherwise
  rdata_idle_a: assert property (@(posedge clk) disable iff (srst)
    !bus_req.rd |=> rdata_r == 32'h0000_0000)
    else $error("read data without a read");

  slp_read_a: assert property (@(posedge clk) disable iff (srst)
    bus_req.rd && bus_req.addr == `DSPCG_OFS_SLP
    |=> rdata_r == $past(sleep_clock_gate_1_r))
    else $error("sleep word read back wrong");

  run_read_a: assert property (@(posedge clk) disable iff (srst)
    bus_req.rd && bus_req.addr == `DSPCG_OFS_RUN
    |=> rdata_r == $past(run_clock_gate_1_r))
    else $error("run word read back wrong");

  unmapped_read_a: assert property (@(posedge clk) disable iff (srst)
    bus_req.rd && bus_req.addr != `DSPCG_OFS_DSL && bus_req.addr != `DSPCG_OFS_SLP
    && bus_req.addr != `DSPCG_OFS_RUN && bus_req.addr != `DSPCG_OFS_MODE_CFG
    |=> rdata_r == 32'h0000_0000)
    else $error("unmapped read not zero");

  // the deep word moves only on a write to its own offset
  dsl_hold_a: assert property (@(posedge clk) disable iff (srst)
    !(bus_req.wr && bus_req.addr == `DSPCG_OFS_DSL) |=> $stable(deep_sleep_clock_gate_1_r))
    else $error("deep-sleep word changed without a write");

  words_reserved_a: assert property (@(posedge clk) disable iff (srst)
    ((sleep_clock_gate_1_r | run_clock_gate_1_r) & ~`DSPCG_GATE_MASK) == 32'h0000_0000)
    else $error("reserved bit set in run or sleep word");

  // full enable map for each word in force
  sleep_select_a: assert property (@(posedge clk) disable iff (srst)
    auto_gating_select && pwr_mode == pm_sleep
    |=> unit_clk_en_r[6:0] == $past({sleep_clock_gate_1_r[24], sleep_clock_gate_1_r[18:16],
    sleep_clock_gate_1_r[4], sleep_clock_gate_1_r[1:0]}))
    else $error("sleep word not in force");

  deep_full_a: assert property (@(posedge clk) disable iff (srst)
    auto_gating_select && pwr_mode == pm_deep
    |=> unit_clk_en_r[6:0] == $past({deep_sleep_clock_gate_1_r[24],
    deep_sleep_clock_gate_1_r[18:16], deep_sleep_clock_gate_1_r[4],
    deep_sleep_clock_gate_1_r[1:0]}))
    else $error("deep-sleep enable map wrong");

  run_word_a: assert property (@(posedge clk) disable iff (srst)
    auto_gating_select && pwr_mode == pm_run
    |=> unit_clk_en_r[6:0] == $past({run_clock_gate_1_r[24], run_clock_gate_1_r[18:16],
    run_clock_gate_1_r[4], run_clock_gate_1_r[1:0]}))
    else $error("run word not in force in run mode");

  // access answers are exclusive and only follow a request
  acc_excl_a: assert property (@(posedge clk) disable iff (srst)
    !(acc_ok_r && acc_fault_r))
    else $error("access both completed and faulted");

  acc_idle_a: assert property (@(posedge clk) disable iff (srst)
    !acc.req |=> !acc_ok_r && !acc_fault_r)
    else $error("answer without a request");

  unit7_fault_a: assert property (@(posedge clk) disable iff (srst)
    acc.req && acc.unit == 3'h7 |=> acc_fault_r)
    else $error("spare unit access did not fault");

endmodule // dspcg_top
`default_nettype wire

// ===== logic/dspcg_consts.svh
`ifndef DSPCG_CONSTS_SVH
`define DSPCG_CONSTS_SVH
// register offsets from the system control base
`define DSPCG_OFS_MODE_CFG 12'h060
`define DSPCG_OFS_RUN 12'h104
`define DSPCG_OFS_SLP 12'h114
`define DSPCG_OFS_DSL 12'h124
// reset values
`define DSPCG_GATE_RST 32'h0000_0000
`define DSPCG_RCC_RST 32'h0000_0000
// writable bits: 24, 18:16, 4, 1:0
`define DSPCG_GATE_MASK 32'h0107_0013
// auto gating select bit in the run mode config
`define DSPCG_AUTO_SEL_BIT 27
// enable bit positions
`define DSPCG_B_CMP_ZERO 24
`define DSPCG_B_TMR2 18
`define DSPCG_B_TMR1 17
`define DSPCG_B_TMR0 16
`define DSPCG_B_SYNC_ZERO 4
`define DSPCG_B_ASYNC_ONE 1
`define DSPCG_B_ASYNC_ZERO 0
// enable vector width: seven units, index 7 spare
`define DSPCG_NUNITS 8
`endif

// ===== logic/dspcg_pkg.sv
`include "dspcg_consts.svh"
package dspcg_pkg;
  // power mode of the chip
  typedef enum logic [1:0] {
    pm_run = 2'b00,
    pm_sleep = 2'b01,
    pm_deep = 2'b10
  } dspcg_mode_t;
  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dspcg_bus_t;
  // access to a peripheral unit
  typedef struct packed {
    logic req;
    logic [2:0] unit;
  } dspcg_acc_t;
endpackage

// ===== dv/dspcg_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dspcg_consts.svh"
module dspcg_top_bench
  import dspcg_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  dspcg_bus_t bus_req = '0;
  dspcg_mode_t pwr_mode = pm_run;
  dspcg_acc_t acc = '0;
  logic [31:0] rdata_r;
  logic acc_ok_r;
  logic acc_fault_r;
  logic [7:0] unit_clk_en_r;
  int err_count = 0;
  int tests_run = 0;
  int bitpos [7] = '{0, 1, 4, 16, 17, 18, 24};
  ////////////////////////////////////////////////////////////////////
  // clock and device
  always #12.5 clk = ~clk;
  dspcg_top u_dspcg_top (
    .clk(clk),
    .srst(srst),
    .bus_req(bus_req),
    .rdata_r(rdata_r),
    .pwr_mode(pwr_mode),
    .acc(acc),
    .acc_ok_r(acc_ok_r),
    .acc_fault_r(acc_fault_r),
    .unit_clk_en_r(unit_clk_en_r)
  );
  ////////////////////////////////////////////////////////////////////
  // compare, verdict and bus tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask
  // read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk) bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    #1 chk("rdata", rdata_r, exp);
  endtask
  // let a register write or mode change reach the enables
  task automatic en_chk(input logic [7:0] exp);
    repeat (2) @(posedge clk);
    #1 chk("unit_clk_en", 32'(unit_clk_en_r), 32'(exp));
  endtask
  task automatic mode(input dspcg_mode_t m, input logic [7:0] exp);
    @(posedge clk) pwr_mode <= m;
    en_chk(exp);
  endtask
  // one access pulse, answer pulse checked then the fall of acc_fault_r
  task automatic acc_chk(input logic [2:0] u, input logic ok);
    @(posedge clk) acc <= '{req: 1'b1, unit: u};
    @(posedge clk) acc.req <= 1'b0;
    #1 chk("acc_ok", 32'(acc_ok_r), 32'(ok));
    chk("acc_fault", 32'(acc_fault_r), 32'(!ok));
    @(posedge clk) #1 chk("fault_fall", 32'(acc_fault_r), 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(`DSPCG_OFS_DSL, 32'h0000_0000);
    chk("reset_en", 32'(unit_clk_en_r), 32'h0000_0000);
    for (int u = 0; u < 8; u++) begin
      acc_chk(3'(u), 1'b0);
    end
    wr(`DSPCG_OFS_DSL, 32'hFFFF_FFFF);
    rd(`DSPCG_OFS_DSL, 32'h0107_0013);
    en_chk(8'h00);
    wr(`DSPCG_OFS_MODE_CFG, 32'h0800_0000);
    rd(`DSPCG_OFS_MODE_CFG, 32'h0800_0000);
    mode(pm_deep, 8'h7F);
    // walk one enable at a time through the deep word
    for (int u = 0; u < 7; u++) begin
      wr(`DSPCG_OFS_DSL, 32'h1 << bitpos[u]);
      en_chk(8'h01 << u);
      acc_chk(3'(u), 1'b1);
      acc_chk(3'(u + 1), 1'b0);
    end
    wr(`DSPCG_OFS_DSL, 32'hFEF8_FFEC);
    rd(`DSPCG_OFS_DSL, 32'h0000_0000);
    en_chk(8'h00);
    wr(`DSPCG_OFS_RUN, 32'h0000_0001);
    wr(`DSPCG_OFS_SLP, 32'h0000_0002);
    rd(`DSPCG_OFS_SLP, 32'h0000_0002);
    mode(pm_sleep, 8'h02);
    mode(pm_run, 8'h01);
    wr(`DSPCG_OFS_MODE_CFG, 32'h0000_0000);
    mode(pm_sleep, 8'h01);
    rd(12'h200, 32'h0000_0000);
    // second reset in mid-run clears every word
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    rd(`DSPCG_OFS_RUN, 32'h0000_0000);
    en_chk(8'h00);
    print_verdict();
  end
  // watchdog far beyond the some 140 cycles the sequence needs
  initial begin
    #(4000 * 25);
    err_count++;
    print_verdict();
  end
endmodule // dspcg_top_bench
`default_nettype wire
